// ==== src/smp_pkg.sv ====
// Package for the stack pop-multiple and frame link sequencer
package smp_pkg;
  localparam int unsigned WORD_BYTES = 4;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] TWO_WORDS = 32'h0000_0008;
  localparam logic [1:0] ALIGN_ZERO = 2'h0;
  localparam int unsigned FRAME_OP_W = 18;
  localparam logic [2:0] DATA_TOP = 3'h7;
  localparam logic [2:0] PTR_TOP = 3'h5;
  localparam int unsigned INSN_W = 32;
  // Register-file destination classes for the load path
  typedef enum logic [1:0] {
    SMP_DST_DATA = 2'h0,
    SMP_DST_PTR = 2'h1,
    SMP_DST_FP = 2'h2,
    SMP_DST_SUBROUTINE_RETURN_ADDRESS = 2'h3
  } smp_dst_t;
  // Operation requested by the issue stage
  typedef enum logic [1:0] {
    SMP_OP_POPM = 2'h0,
    SMP_OP_LINK = 2'h1,
    SMP_OP_UNLINK = 2'h2,
    SMP_OP_NONE = 2'h3
  } smp_op_t;
  typedef enum logic [5:0] {
    SMP_IDLE = 6'h01,
    SMP_POP_P = 6'h02,
    SMP_POP_D = 6'h04,
    SMP_LNK_SUBROUTINE_RETURN_ADDRESS = 6'h08,
    SMP_LNK_FP = 6'h10,
    SMP_UNL_LD = 6'h20
  } smp_state_t;
endpackage

// ==== src/smp_seq.sv ====
// Stack pop-multiple and frame allocate/release sequencer
`timescale 1ns/1ps
`default_nettype none

// Function
// [R01] Pop contiguous range from top to low index
// [R02] Highest index first, descending per class
// [R03] All pointer registers before data registers
// [R04] Read at stack_pointer, then add four
// [R05] Pops never write stack memory
// [R06] Hold off interrupts after first read
// [R07] Exception aborts, restores stack_pointer
// [R08] Unaligned stack_pointer raises exception, aborts
// [R09] Only P5-0 and R7-0 as destinations
// [R10] Pop multiple: 16-bit, alone, flags unchanged
// [R11] Single pops of other registers issue alone
// [R12] Software pops what it pushed, reversed
// [R13] Frame size 18-bit multiple of four
// [R14] Allocate pushes return address, frame_pointer
// [R15] Allocate always uses two words
// [R16] Release copies frame_pointer, reloads both
// [R17] Frame ops uninterruptible, restore on exception
// [R18] Completed accesses stay after abort
// [R19] Software keeps frame_pointer between them
// [R20] One access per step, stall until done
module smp_seq
  import smp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_issue_valid,
  input wire smp_pkg::smp_op_t i_issue_op,
  input wire logic i_issue_is_32bit,
  input wire logic i_issue_parallel,
  input wire logic i_popm_data_en,
  input wire logic [2:0] i_popm_data_low,
  input wire logic i_popm_ptr_en,
  input wire logic [2:0] i_popm_ptr_low,
  input wire logic [FRAME_OP_W-1:0] i_frame_size,
  input wire logic [31:0] i_stack_pointer,
  input wire logic [31:0] i_frame_pointer,
  input wire logic [31:0] i_subroutine_return_address,
  output logic o_issue_ready,
  output logic o_stall,
  output logic o_irq_hold,
  output logic o_illegal,
  output logic o_done,
  output logic o_abort,
  output logic o_flags_we,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_mem_exc,
  output logic o_rf_we,
  output smp_pkg::smp_dst_t o_rf_dst,
  output logic [2:0] o_rf_idx,
  output logic [31:0] o_rf_wdata,
  output logic o_sp_we,
  output logic [31:0] o_sp_wdata,
  output logic o_fp_we,
  output logic [31:0] o_fp_wdata
);
  import smp_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  smp_state_t state;
  smp_state_t next_state;
  logic [31:0] sp_cur;
  logic [31:0] sp_save;
  logic [31:0] fp_save;
  logic [2:0] idx;
  logic [2:0] d_low;
  logic d_en;
  logic [2:0] p_low;
  logic unl_second;
  logic [FRAME_OP_W-1:0] fsize;
  logic accept;
  logic bad_issue;
  logic step_ok;
  logic step_exc;
  logic last_step;
  logic unaligned;

  // ------------------------------------------------------------
  // Issue decode
  // ------------------------------------------------------------
  assign o_issue_ready = (state == SMP_IDLE);
  // [R10] Issue form checks
  // [R13] Length and operand checks
  // [R09] Operand range checks
  // [R11] Alone-only issue
  always_comb begin
    bad_issue = i_issue_parallel;
    case (i_issue_op)
      SMP_OP_POPM: begin
        bad_issue = bad_issue | i_issue_is_32bit | ~(i_popm_data_en | i_popm_ptr_en) |
                    (i_popm_ptr_en & (i_popm_ptr_low > PTR_TOP));
      end
      SMP_OP_LINK: begin
        bad_issue = bad_issue | ~i_issue_is_32bit | (i_frame_size[1:0] != ALIGN_ZERO);
      end
      SMP_OP_UNLINK: begin
        bad_issue = bad_issue | ~i_issue_is_32bit;
      end
      default: begin
        bad_issue = 1'b1;
      end
    endcase
  end
  assign accept = i_issue_valid & o_issue_ready;

  // [R08] Alignment check
  // Unaligned pointer aborts before any access is issued
  assign unaligned = (sp_cur[1:0] != ALIGN_ZERO);
  assign step_exc = (state != SMP_IDLE) & (i_mem_exc | unaligned);
  assign step_ok = (state != SMP_IDLE) & ~step_exc & i_mem_ack;
  always_comb begin
    case (state)
      SMP_POP_P: last_step = (idx == p_low) & ~d_en;
      SMP_POP_D: last_step = (idx == d_low);
      SMP_LNK_FP: last_step = 1'b1;
      SMP_UNL_LD: last_step = unl_second;
      default: last_step = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // [R03] Pointers first, then data
  always_comb begin
    next_state = state;
    case (state)
      SMP_IDLE: begin
        if (accept & ~bad_issue) begin
          if (i_issue_op == SMP_OP_LINK) begin
            next_state = SMP_LNK_SUBROUTINE_RETURN_ADDRESS;
          end else if (i_issue_op == SMP_OP_UNLINK) begin
            next_state = SMP_UNL_LD;
          end else if (i_popm_ptr_en) begin
            next_state = SMP_POP_P;
          end else begin
            next_state = SMP_POP_D;
          end
        end
      end
      SMP_POP_P: begin
        if (step_exc | (step_ok & last_step)) begin
          next_state = SMP_IDLE;
        end else if (step_ok & (idx == p_low)) begin
          next_state = SMP_POP_D;
        end
      end
      SMP_LNK_SUBROUTINE_RETURN_ADDRESS: begin
        if (step_exc) begin
          next_state = SMP_IDLE;
        end else if (step_ok) begin
          next_state = SMP_LNK_FP;
        end
      end
      SMP_POP_D, SMP_LNK_FP, SMP_UNL_LD: begin
        if (step_exc | (step_ok & last_step)) begin
          next_state = SMP_IDLE;
        end
      end
      default: begin
        next_state = SMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= SMP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // [R01] Capture range, start at top
  // [R02] Descend one index per word
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx <= 3'h0;
      d_low <= 3'h0;
      d_en <= 1'b0;
      p_low <= 3'h0;
    end else if (accept & ~bad_issue) begin
      idx <= i_popm_ptr_en ? PTR_TOP : DATA_TOP;
      d_low <= i_popm_data_low;
      d_en <= i_popm_data_en;
      p_low <= i_popm_ptr_low;
    end else if (step_ok) begin
      if ((state == SMP_POP_P) & (idx == p_low)) begin
        idx <= DATA_TOP;
      end else begin
        idx <= idx - 3'h1;
      end
    end
  end

  // Working stack pointer and pre-instruction copies
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sp_cur <= 32'h0000_0000;
      sp_save <= 32'h0000_0000;
      fp_save <= 32'h0000_0000;
      fsize <= '0;
      unl_second <= 1'b0;
    end else if (accept & ~bad_issue) begin
      sp_save <= i_stack_pointer;
      fp_save <= i_frame_pointer;
      fsize <= i_frame_size;
      unl_second <= 1'b0;
      // [R16] Release starts from frame_pointer
      if (i_issue_op == SMP_OP_UNLINK) begin
        sp_cur <= i_frame_pointer;
      end else begin
        sp_cur <= i_stack_pointer;
      end
    end else if (step_ok) begin
      case (state)
        // [R04] Post-increment after read
        SMP_POP_P, SMP_POP_D, SMP_UNL_LD: begin
          sp_cur <= sp_cur + WORD_STEP;
          unl_second <= 1'b1;
        end
        // [R14] Pre-decrement pushes
        SMP_LNK_SUBROUTINE_RETURN_ADDRESS: begin
          sp_cur <= sp_cur - WORD_STEP;
        end
        default: begin
          sp_cur <= sp_cur;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Memory access
  // ------------------------------------------------------------
  // [R20] One word access per step
  // [R05] Pops only read
  always_comb begin
    o_mem_req = ~unaligned & (state != SMP_IDLE);
    o_mem_we = (state == SMP_LNK_SUBROUTINE_RETURN_ADDRESS) | (state == SMP_LNK_FP);
  end

  // ------------------------------------------------------------
  // Registered access address and store data
  // ------------------------------------------------------------
  // [R14] Pushes address one word below pointer
  // Return address taken at issue, later changes are harmless
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mem_addr <= 32'h0000_0000;
      o_mem_wdata <= 32'h0000_0000;
    end else if (accept & ~bad_issue) begin
      o_mem_wdata <= i_subroutine_return_address;
      if (i_issue_op == SMP_OP_LINK) begin
        o_mem_addr <= i_stack_pointer - WORD_STEP;
      end else if (i_issue_op == SMP_OP_UNLINK) begin
        o_mem_addr <= i_frame_pointer;
      end else begin
        o_mem_addr <= i_stack_pointer;
      end
    end else if (step_ok) begin
      o_mem_wdata <= fp_save;
      if (state == SMP_LNK_SUBROUTINE_RETURN_ADDRESS) begin
        o_mem_addr <= o_mem_addr - WORD_STEP;
      end else begin
        o_mem_addr <= o_mem_addr + WORD_STEP;
      end
    end
  end

  // [R20] Stall while sequencing
  assign o_stall = (state != SMP_IDLE);
  // [R06] Interrupts held off
  // [R17] Frame ops uninterruptible
  assign o_irq_hold = (state != SMP_IDLE);
  // [R10] Flags untouched
  assign o_flags_we = 1'b0;

  // ------------------------------------------------------------
  // Register-file and pointer writeback (registered)
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rf_we <= 1'b0;
      o_rf_dst <= SMP_DST_DATA;
      o_rf_idx <= 3'h0;
      o_rf_wdata <= 32'h0000_0000;
      o_sp_we <= 1'b0;
      o_sp_wdata <= 32'h0000_0000;
      o_fp_we <= 1'b0;
      o_fp_wdata <= 32'h0000_0000;
      o_done <= 1'b0;
      o_abort <= 1'b0;
      o_illegal <= 1'b0;
    end else begin
      // [R18] Completed loads stay written
      o_rf_we <= step_ok & ~o_mem_we;
      o_rf_idx <= idx;
      o_rf_wdata <= i_mem_rdata;
      case (state)
        SMP_POP_P: o_rf_dst <= SMP_DST_PTR;
        SMP_UNL_LD: o_rf_dst <= unl_second ? SMP_DST_SUBROUTINE_RETURN_ADDRESS : SMP_DST_FP;
        default: o_rf_dst <= SMP_DST_DATA;
      endcase
      o_illegal <= accept & bad_issue;
      o_done <= step_ok & last_step;
      o_abort <= step_exc;
      o_sp_we <= 1'b0;
      o_fp_we <= 1'b0;
      if (step_exc) begin
        // [R07] Restore stack_pointer on abort
        // [R17] Restore stack_pointer; restore frame_pointer for allocate only
        o_sp_we <= 1'b1;
        o_sp_wdata <= sp_save;
        // A release keeps any frame_pointer already reloaded
        o_fp_we <= (state == SMP_LNK_SUBROUTINE_RETURN_ADDRESS) | (state == SMP_LNK_FP);
        o_fp_wdata <= fp_save;
      end else if (step_ok & last_step) begin
        o_sp_we <= 1'b1;
        if (state == SMP_LNK_FP) begin
          // [R15] Two saved words plus frame
          o_sp_wdata <= sp_cur - TWO_WORDS - {{(32-FRAME_OP_W){1'b0}}, fsize} + WORD_STEP;
          o_fp_we <= 1'b1;
          o_fp_wdata <= sp_cur - WORD_STEP;
        end else begin
          o_sp_wdata <= sp_cur + WORD_STEP;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ==== dv/smp_mem_model.sv ====
// Data memory model answering the sequencer's stack accesses
`timescale 1ns/1ps
`default_nettype none
module smp_mem_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [1:0] i_lat,
  input wire logic [31:0] i_exc_addr,
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic o_exc
);
  logic [31:0] mem [16];
  logic [1:0] cnt;
  logic hit;
  assign hit = i_req && (cnt == i_lat);
  assign o_exc = hit && (i_addr == i_exc_addr);
  assign o_ack = hit && !o_exc;
  // Read data only valid with ack, inverted otherwise
  assign o_rdata = o_ack ? mem[i_addr[5:2]] : ~mem[i_addr[5:2]];
  initial for (int i = 0; i < 16; i++) mem[i] = 32'hC0DE_0000 + i;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) cnt <= 2'h0;
    else cnt <= (hit || !i_req) ? 2'h0 : cnt + 2'h1;
  end
  always @(posedge i_clk) if (o_ack && i_we) mem[i_addr[5:2]] <= i_wdata;
endmodule
`default_nettype wire

// ==== dv/smp_seq_asserts.sv ====
// Checker for the stack sequencer ports
`timescale 1ns/1ps
`default_nettype none
module smp_seq_asserts
  import smp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_issue_valid,
  input wire smp_pkg::smp_op_t i_issue_op,
  input wire logic i_issue_parallel,
  input wire logic [31:0] i_stack_pointer,
  input wire logic i_mem_ack,
  input wire logic i_mem_exc,
  input wire logic o_issue_ready,
  input wire logic o_stall,
  input wire logic o_irq_hold,
  input wire logic o_illegal,
  input wire logic o_done,
  input wire logic o_abort,
  input wire logic o_flags_we,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [31:0] o_mem_addr,
  input wire logic o_rf_we,
  input wire smp_pkg::smp_dst_t o_rf_dst,
  input wire logic o_sp_we,
  input wire logic [31:0] o_sp_wdata
);
  import smp_pkg::*;
  logic taken;
  logic data_seen;
  smp_op_t op_q;
  logic [31:0] sp_q;
  assign taken = i_issue_valid && o_issue_ready;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_q <= SMP_OP_NONE;
      sp_q <= 32'h0;
    end else if (taken) begin
      op_q <= i_issue_op;
      sp_q <= i_stack_pointer;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) data_seen <= 1'b0;
    else if (taken) data_seen <= 1'b0;
    else if (o_rf_we && o_rf_dst == SMP_DST_DATA) data_seen <= 1'b1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  flags_kept_a: assert property (!o_flags_we) else $error("flags written");
  irq_held_a: assert property (o_mem_req |-> o_irq_hold && o_stall) else $error("irq not held");
  busy_refuse_a: assert property (o_stall |-> !o_issue_ready) else $error("ready while busy");
  pop_no_store_a: assert property (o_mem_req && op_q != SMP_OP_LINK |-> !o_mem_we) else $error("pop wrote");
  sp_step_a: assert property (o_mem_req && i_mem_ack && op_q == SMP_OP_POPM ##1 o_mem_req
    |-> o_mem_addr == $past(o_mem_addr) + WORD_STEP) else $error("pop address step wrong");
  req_aligned_a: assert property (o_mem_req |-> o_mem_addr[1:0] == ALIGN_ZERO) else $error("unaligned access");
  par_refused_a: assert property (taken && i_issue_parallel |=> o_illegal && !o_stall) else $error("parallel taken");
  exc_abort_a: assert property (o_mem_req && i_mem_exc |=> o_abort) else $error("no abort");
  abort_sp_a: assert property (o_abort |-> o_sp_we && o_sp_wdata == sp_q) else $error("sp not restored");
  ptr_first_a: assert property (o_rf_we && o_rf_dst == SMP_DST_PTR |-> !data_seen) else $error("ptr after data");
  cover property (o_done && op_q == SMP_OP_POPM);
  cover property (o_done && op_q == SMP_OP_UNLINK);
  cover property (o_abort);
endmodule
bind smp_seq smp_seq_asserts u_smp_seq_asserts (.*);
`default_nettype wire

// ==== dv/smp_seq_tb_top.sv ====
// Self-checking bench for the stack sequencer
`timescale 1ns/1ps
`default_nettype none
module smp_seq_tb_top;
  import smp_pkg::*;
  logic i_clk, i_arst_n, i_issue_valid, i_issue_is_32bit, i_issue_parallel, i_popm_data_en, i_popm_ptr_en;
  smp_op_t i_issue_op;
  logic [2:0] i_popm_data_low, i_popm_ptr_low, o_rf_idx;
  logic [FRAME_OP_W-1:0] i_frame_size;
  logic [31:0] i_stack_pointer, i_frame_pointer, i_subroutine_return_address, i_mem_rdata, o_mem_addr, o_mem_wdata;
  logic [31:0] o_rf_wdata, o_sp_wdata, o_fp_wdata, exc_addr, sps, fps;
  logic i_mem_ack, i_mem_exc, o_issue_ready, o_stall, o_irq_hold, o_illegal, o_done, o_abort, o_flags_we;
  logic o_mem_req, o_mem_we, o_rf_we, o_sp_we, o_fp_we;
  smp_dst_t o_rf_dst;
  logic [1:0] lat;
  logic [31:0] rd [8];
  logic [4:0] rt [8];
  logic [2:0] st;
  int n, error_cnt, cmp_count;
  smp_seq u_smp_seq (.*);
  smp_mem_model u_smp_mem_model (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_lat(lat), .i_exc_addr(exc_addr), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata), .o_exc(i_mem_exc));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // Issue one instruction and log loads, SP/FP writes and final status
  task automatic go(input smp_op_t op, input logic [3:0] d, input logic [3:0] p, input logic [31:0] sp,
                    input logic [17:0] sz, input logic [1:0] x);
    {n, sps, fps, st} = '0;
    @(posedge i_clk);
    i_issue_valid <= 1'b1;
    i_issue_op <= op;
    i_issue_is_32bit <= (op != SMP_OP_POPM) ^ x[1];
    i_issue_parallel <= x[0];
    {i_popm_data_en, i_popm_data_low} <= d;
    {i_popm_ptr_en, i_popm_ptr_low} <= p;
    i_stack_pointer <= sp;
    i_frame_size <= sz;
    repeat (40) begin
      @(posedge i_clk);
      i_issue_valid <= 1'b0;
      #1;
      if (o_rf_we === 1'b1) begin
        rd[n] = o_rf_wdata;
        rt[n] = {o_rf_dst, o_rf_idx};
        n++;
      end
      if (o_sp_we === 1'b1) sps = o_sp_wdata;
      if (o_fp_we === 1'b1) fps = o_fp_wdata;
      st = {o_done, o_abort, o_illegal};
      if (st != 3'h0) break;
    end
  endtask
  task automatic t_popm;
    go(SMP_OP_POPM, 4'hE, 4'hC, 32'h0000_0010, 18'h0, 2'h0);
    chk("count", 4, n);
    for (int i = 0; i < 4; i++) begin
      chk("data", 32'hC0DE_0004 + i, rd[i]);
      chk("dest", (i < 2) ? {SMP_DST_PTR, 3'(5 - i)} : {SMP_DST_DATA, 3'(9 - i)}, rt[i]);
    end
    chk("sp", 32'h0000_0020, sps);
    chk("kept", 32'hC0DE_0004, u_smp_mem_model.mem[4]);
    chk("status", 3'h4, st);
    $display("popm test over");
  endtask
  task automatic t_frame;
    lat = 2'h3;
    @(posedge i_clk);
    i_frame_pointer <= 32'h0000_0100;
    i_subroutine_return_address <= 32'h0000_0200;
    go(SMP_OP_LINK, 4'h0, 4'h0, 32'h0000_0030, 18'h10, 2'h0);
    chk("subroutine_return_address_saved", 32'h0000_0200, u_smp_mem_model.mem[11]);
    chk("fp_saved", 32'h0000_0100, u_smp_mem_model.mem[10]);
    chk("fp_new", 32'h0000_0028, fps);
    chk("sp_new", 32'h0000_0018, sps);
    // frame_pointer kept as allocate left it
    @(posedge i_clk);
    i_frame_pointer <= 32'h0000_0028;
    go(SMP_OP_UNLINK, 4'h0, 4'h0, 32'h0000_0018, 18'h0, 2'h0);
    chk("fp_back", 32'h0000_0100, rd[0]);
    chk("subroutine_return_address_back", 32'h0000_0200, rd[1]);
    chk("dsts", {SMP_DST_FP, SMP_DST_SUBROUTINE_RETURN_ADDRESS}, {rt[0][4:3], rt[1][4:3]});
    chk("sp_back", 32'h0000_0030, sps);
    $display("frame test over");
  endtask
  task automatic t_abort;
    exc_addr = 32'h0000_0018;
    go(SMP_OP_POPM, 4'h0, 4'h8, 32'h0000_0010, 18'h0, 2'h0);
    chk("pop_abort", 3'h2, st);
    chk("kept_loads", 2, n);
    chk("sp_restore", 32'h0000_0010, sps);
    exc_addr = 32'h0000_0028;
    @(posedge i_clk);
    i_subroutine_return_address <= 32'h0000_0300;
    go(SMP_OP_LINK, 4'h0, 4'h0, 32'h0000_0030, 18'h10, 2'h0);
    chk("link_abort", 3'h2, st);
    chk("link_sp", 32'h0000_0030, sps);
    chk("link_fp", 32'h0000_0028, fps);
    chk("store_left", 32'h0000_0300, u_smp_mem_model.mem[11]);
    go(SMP_OP_POPM, 4'hF, 4'h0, 32'h0000_0012, 18'h0, 2'h0);
    chk("unaligned", 3'h2, st);
    chk("no_loads", 0, n);
    $display("abort test over");
  endtask
  task automatic t_refuse;
    go(SMP_OP_POPM, 4'hF, 4'h0, 32'h0000_0010, 18'h0, 2'h1);
    chk("parallel", 3'h1, st);
    go(SMP_OP_POPM, 4'hF, 4'h0, 32'h0000_0010, 18'h0, 2'h2);
    chk("length", 3'h1, st);
    go(SMP_OP_POPM, 4'h0, 4'hE, 32'h0000_0010, 18'h0, 2'h0);
    chk("ptr_low", 3'h1, st);
    go(SMP_OP_LINK, 4'h0, 4'h0, 32'h0000_0030, 18'h2, 2'h0);
    chk("size", 3'h1, st);
    go(SMP_OP_UNLINK, 4'h0, 4'h0, 32'h0000_0018, 18'h0, 2'h2);
    chk("unl_length", 3'h1, st);
    go(SMP_OP_POPM, 4'h0, 4'h0, 32'h0000_0010, 18'h0, 2'h0);
    chk("no_range", 3'h1, st);
    go(SMP_OP_NONE, 4'hF, 4'h0, 32'h0000_0010, 18'h0, 2'h0);
    chk("no_op", 3'h1, st);
    $display("refuse test over");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {i_arst_n, i_issue_valid, i_issue_is_32bit, i_issue_parallel, i_popm_data_en, i_popm_ptr_en} = '0;
    {i_popm_data_low, i_popm_ptr_low, i_frame_size, i_stack_pointer, i_frame_pointer, i_subroutine_return_address} = '0;
    i_issue_op = SMP_OP_NONE;
    {error_cnt, cmp_count, lat} = '0;
    exc_addr = 32'hFFFF_FFF0;
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_popm;
    t_frame;
    t_abort;
    t_refuse;
    tally_and_finish;
  end
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
